//--- rtl/bid_decoder.sv
// Instruction decoder and executor for the baseline 12-bit core
// Functional notes
// - d=0 result to accumulator, d=1 to file
// - add and subtract update carry, digit, zero
// - AND, OR, XOR with file update zero
// - rotate left/right through carry, carry only
// - dec/inc skip on zero, no flags
// - bit test skips next when bit clear
// - bit test skips next when bit set
// - literal AND, OR, XOR into accumulator, zero
// - return with literal loads accumulator, two cycles
// - standby word sets timeout status, clears powerdown status
// - PC writes except branch clear bit nine
// - read-modify-write of port uses pin levels
// - load pin direction from accumulator, file 6
// - direction bit one disables output driver
// - timer write clears assigned prescaler
// - one cycle, two when skip or branch
// - taken skip replaces fetched word with no-op
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module bid_decoder
  import bid_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Program memory
  output logic [8:0] fetch_addr,
  input wire logic [11:0] instr,
  // General port pins
  input wire logic [7:0] port_pin_in,
  output logic [7:0] port_pin_out,
  output logic [7:0] port_pin_oe,
  // Core state
  output logic standby,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata
);

  bid_state_t s;
  bid_state_t n;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] get_file(bid_state_t st, logic [4:0] a);
    logic [7:0] v;
    case (a)
      BID_FILE_TIMER: v = st.timer;
      BID_FILE_PCL: v = st.pc[7:0];
      BID_FILE_STATUS: v = {3'h0, st.to_n, st.pd_n, st.z, st.dc, st.c};
      // Port reads see the pins, not the latch
      BID_FILE_PORT: v = st.pin_s2;
      default: v = st.file[a];
    endcase
    return v;
  endfunction

  function automatic bid_state_t put_file(bid_state_t st, logic [4:0] a, logic [7:0] v);
    bid_state_t r;
    r = st;
    case (a)
      BID_FILE_TIMER: begin
        r.timer = v;
        if (st.ctrl[BID_CTRL_PRESC_BIT]) begin
          r.presc = 8'h00;
        end
      end
      BID_FILE_PCL: begin
        r.pc = {1'b0, v};
        r.flush = 1'b1;
      end
      BID_FILE_STATUS: begin
        r.c = v[BID_ST_C];
        r.dc = v[BID_ST_DC];
        r.z = v[BID_ST_Z];
      end
      BID_FILE_PORT: r.port_latch = v;
      default: r.file[a] = v;
    endcase
    return r;
  endfunction

  function automatic logic [15:0] bus_read(bid_state_t st, logic [2:0] a);
    logic [15:0] v;
    case (a)
      BID_REG_CTRL: v = {8'h00, st.ctrl};
      BID_REG_STATUS: v = {10'h000, st.sleeping, st.to_n, st.pd_n, st.z, st.dc, st.c};
      BID_REG_ACC: v = {8'h00, st.w};
      BID_REG_PC: v = {7'h00, st.pc};
      BID_REG_OPTION: v = {8'h00, st.option};
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [4:0] fa;
    logic dst_file;
    logic [7:0] opnd;
    logic [7:0] lit;
    logic [7:0] res;
    logic [8:0] wide;
    logic [4:0] half;
    logic wr;
    logic upd_z;
    logic upd_c;
    logic upd_dc;
    logic nc;
    logic ndc;
    fa = instr[4:0];
    dst_file = instr[5];
    lit = instr[7:0];
    res = 8'h00;
    wide = 9'h000;
    half = 5'h00;
    wr = 1'b0;
    upd_z = 1'b0;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    nc = 1'b0;
    ndc = 1'b0;
    n = s;
    n.pin_s1 = port_pin_in;
    n.pin_s2 = s.pin_s1;
    opnd = get_file(s, fa);

    // Register port
    n.rd_data = 16'h0000;
    if (reg_rd) begin
      n.rd_data = bus_read(s, reg_addr);
    end
    if (reg_wr && reg_addr == BID_REG_CTRL) begin
      n.ctrl = reg_wdata[7:0];
    end

    // Timer keeps counting in standby; prescaled only when assigned
    if (s.ctrl[BID_CTRL_PRESC_BIT]) begin
      n.presc = s.presc + 8'h01;
      if (s.presc == 8'hFF) begin
        n.timer = s.timer + 8'h01;
      end
    end else begin
      n.timer = s.timer + 8'h01;
    end

    if (!s.sleeping) begin
      n.pc = s.pc + 9'h001;
      n.flush = 1'b0;
      // A discarded word executes as a no-op
      if (!s.flush) begin
        if (instr[11:10] == 2'b00) begin
          case (instr[9:6])
            4'h0: begin
              if (dst_file) begin
                res = s.w;
                wr = 1'b1;
              end else if (instr == BID_W_OPTION) begin
                n.option = s.w;
              end else if (instr == BID_W_STANDBY) begin
                n.to_n = 1'b1;
                n.pd_n = 1'b0;
                n.sleeping = 1'b1;
              end else if (instr == BID_W_CLRWDT) begin
                n.to_n = 1'b1;
                n.pd_n = 1'b1;
              end else if (instr[4:0] == {2'b00, BID_DIR_PORT_SEL}) begin
                // A one turns the driver off
                n.port_oe = ~s.w;
              end
              // Remaining words of the group fall through as no-ops
            end
            4'h1: begin
              res = 8'h00;
              wr = 1'b1;
              upd_z = 1'b1;
            end
            4'h2: begin
              wide = {1'b0, opnd} + {1'b0, ~s.w} + 9'h001;
              half = {1'b0, opnd[3:0]} + {1'b0, ~s.w[3:0]} + 5'h01;
              res = wide[7:0];
              nc = wide[8];
              ndc = half[4];
              wr = 1'b1;
              upd_z = 1'b1;
              upd_c = 1'b1;
              upd_dc = 1'b1;
            end
            4'h3: begin
              res = opnd - 8'h01;
              wr = 1'b1;
              upd_z = 1'b1;
            end
            4'h4: begin
              res = s.w | opnd;
              wr = 1'b1;
              upd_z = 1'b1;
            end
            4'h5: begin
              res = s.w & opnd;
              wr = 1'b1;
              upd_z = 1'b1;
            end
            4'h6: begin
              res = s.w ^ opnd;
              wr = 1'b1;
              upd_z = 1'b1;
            end
            4'h7: begin
              wide = {1'b0, opnd} + {1'b0, s.w};
              half = {1'b0, opnd[3:0]} + {1'b0, s.w[3:0]};
              res = wide[7:0];
              nc = wide[8];
              ndc = half[4];
              wr = 1'b1;
              upd_z = 1'b1;
              upd_c = 1'b1;
              upd_dc = 1'b1;
            end
            4'h8: begin
              res = opnd;
              wr = 1'b1;
              upd_z = 1'b1;
            end
            4'h9: begin
              res = ~opnd;
              wr = 1'b1;
              upd_z = 1'b1;
            end
            4'hA: begin
              res = opnd + 8'h01;
              wr = 1'b1;
              upd_z = 1'b1;
            end
            4'hB, 4'hF: begin
              res = (instr[9:6] == 4'hB) ? opnd - 8'h01 : opnd + 8'h01;
              wr = 1'b1;
              if (res == 8'h00) begin
                n.flush = 1'b1;
              end
            end
            4'hC: begin
              res = {s.c, opnd[7:1]};
              nc = opnd[0];
              wr = 1'b1;
              upd_c = 1'b1;
            end
            4'hD: begin
              res = {opnd[6:0], s.c};
              nc = opnd[7];
              wr = 1'b1;
              upd_c = 1'b1;
            end
            4'hE: begin
              res = {opnd[3:0], opnd[7:4]};
              wr = 1'b1;
            end
            default: begin
              wr = 1'b0;
            end
          endcase
        end else begin
          case (instr[11:8])
            4'h4: n = put_file(n, fa, opnd & ~(8'h01 << instr[7:5]));
            4'h5: n = put_file(n, fa, opnd | (8'h01 << instr[7:5]));
            4'h6: begin
              if (!opnd[instr[7:5]]) begin
                n.flush = 1'b1;
              end
            end
            4'h7: begin
              if (opnd[instr[7:5]]) begin
                n.flush = 1'b1;
              end
            end
            4'h8: begin
              n.w = lit;
              n.pc = {1'b0, s.stk0[7:0]};
              n.stk0 = s.stk1;
              n.flush = 1'b1;
            end
            4'h9: begin
              n.stk1 = s.stk0;
              n.stk0 = s.pc;
              n.pc = {1'b0, lit};
              n.flush = 1'b1;
            end
            4'hA, 4'hB: begin
              // The branch alone may set bit nine
              n.pc = instr[8:0];
              n.flush = 1'b1;
            end
            4'hC: n.w = lit;
            4'hD: begin
              res = s.w | lit;
              n.w = res;
              upd_z = 1'b1;
            end
            4'hE: begin
              res = s.w & lit;
              n.w = res;
              upd_z = 1'b1;
            end
            4'hF: begin
              res = s.w ^ lit;
              n.w = res;
              upd_z = 1'b1;
            end
            default: begin
              n.flush = n.flush;
            end
          endcase
        end
        if (wr) begin
          if (dst_file) begin
            n = put_file(n, fa, res);
          end else begin
            n.w = res;
          end
        end
        // Instruction flags win over a direct write of the status file
        if (upd_z) begin
          n.z = (res == 8'h00);
        end
        if (upd_c) begin
          n.c = nc;
        end
        if (upd_dc) begin
          n.dc = ndc;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      s <= '0;
      s.to_n <= 1'b1;
      s.pd_n <= 1'b1;
      s.pc <= BID_PC_RESET;
      // First fetched word after reset is not yet valid
      s.flush <= 1'b1;
      s.option <= BID_OPTION_RESET;
      s.port_oe <= ~BID_DIR_RESET;
      s.ctrl <= BID_CTRL_RESET;
    end else begin
      s <= n;
    end
  end

  assign fetch_addr = s.pc;
  assign port_pin_out = s.port_latch;
  assign port_pin_oe = s.port_oe;
  assign standby = s.sleeping;
  assign reg_rdata = s.rd_data;

endmodule // bid_decoder
`default_nettype wire

//--- rtl/bid_pkg.sv
// Package of constants and state type for the 12-bit instruction decoder
package bid_pkg;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam logic [2:0] BID_REG_CTRL = 3'h0;
  localparam logic [2:0] BID_REG_STATUS = 3'h1;
  localparam logic [2:0] BID_REG_ACC = 3'h2;
  localparam logic [2:0] BID_REG_PC = 3'h3;
  localparam logic [2:0] BID_REG_OPTION = 3'h4;
  localparam int BID_CTRL_PRESC_BIT = 0;
  localparam logic [7:0] BID_CTRL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // File addresses with special meaning
  // ----------------------------------------------------------------
  localparam logic [4:0] BID_FILE_TIMER = 5'h01;
  localparam logic [4:0] BID_FILE_PCL = 5'h02;
  localparam logic [4:0] BID_FILE_STATUS = 5'h03;
  localparam logic [4:0] BID_FILE_PORT = 5'h06;
  localparam logic [2:0] BID_DIR_PORT_SEL = 3'h6;

  // Status byte bit positions inside file 3 and the status register
  localparam int BID_ST_C = 0;
  localparam int BID_ST_DC = 1;
  localparam int BID_ST_Z = 2;
  localparam int BID_ST_PD = 3;
  localparam int BID_ST_TO = 4;
  localparam int BID_ST_SLEEP = 5;

  // ----------------------------------------------------------------
  // Fixed words of the misc group
  // ----------------------------------------------------------------
  localparam logic [11:0] BID_W_NOP = 12'h000;
  localparam logic [11:0] BID_W_OPTION = 12'h002;
  localparam logic [11:0] BID_W_STANDBY = 12'h003;
  localparam logic [11:0] BID_W_CLRWDT = 12'h004;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [8:0] BID_PC_RESET = 9'h000;
  localparam logic [7:0] BID_DIR_RESET = 8'hFF;
  localparam logic [7:0] BID_OPTION_RESET = 8'hFF;

  typedef struct packed {
    logic [31:0][7:0] file;
    logic [7:0] w;
    logic c;
    logic dc;
    logic z;
    logic to_n;
    logic pd_n;
    logic [8:0] pc;
    logic [8:0] stk0;
    logic [8:0] stk1;
    logic flush;
    logic sleeping;
    logic [7:0] timer;
    logic [7:0] presc;
    logic [7:0] option;
    logic [7:0] port_latch;
    logic [7:0] port_oe;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic [7:0] ctrl;
    logic [15:0] rd_data;
  } bid_state_t;

endpackage

//--- sim/bid_properties.sv
// Port-level checks for the instruction decoder
`timescale 1ns/1ns
`default_nettype none
module bid_properties
  import bid_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Fetch, pins and state
  input wire logic [8:0] fetch_addr,
  input wire logic [11:0] instr,
  input wire logic [7:0] port_pin_out,
  input wire logic [7:0] port_pin_oe,
  input wire logic standby,
  // Register port
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_rdata_idle:
    assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside answer cycle");
  chk_reset_fetch:
    assert property ($rose(rst_b) |-> fetch_addr == BID_PC_RESET ##1 fetch_addr == 9'h001)
    else $error("fetch does not start at zero");
  chk_dir_load_only:
    assert property ($changed(port_pin_oe) |-> $past(instr) == 12'h006)
    else $error("pin drivers changed without direction load");
  chk_port_write_src:
    assert property ($changed(port_pin_out) |-> $past(instr[4:0]) == BID_FILE_PORT)
    else $error("port latch changed without port write");
  chk_standby_entry:
    assert property ($rose(standby) |-> $past(instr) == BID_W_STANDBY)
    else $error("standby entered without standby word");
  chk_standby_holds:
    assert property (standby |=> standby)
    else $error("standby left without reset");
  chk_branch_target:
    assert property (instr[11:9] == 3'b101 && !standby |=>
      fetch_addr == $past(instr[8:0]) || fetch_addr == $past(fetch_addr) + 9'h001)
    else $error("branch went to wrong address");
  chk_seq_fetch:
    assert property (instr[11:10] != 2'b10 && instr[4:0] != BID_FILE_PCL &&
      instr != BID_W_STANDBY && !standby |=> fetch_addr == $past(fetch_addr) + 9'h001)
    else $error("plain word did not advance fetch by one");
  cov_standby: cover property ($rose(standby));
  cov_branch: cover property (instr[11:9] == 3'b101);
  cov_dir_load: cover property ($changed(port_pin_oe));
endmodule // bid_properties
`default_nettype wire

//--- sim/bid_prog_mem.sv
// Program memory model answering one cycle after the fetch address
`timescale 1ns/1ns
`default_nettype none
module bid_prog_mem (
  // Clock
  input wire logic core_clk,
  // Fetch port
  input wire logic [8:0] fetch_addr,
  output logic [11:0] instr = 12'h000
);
  // Loaded by the bench only while the core is held in reset
  logic [11:0] mem [0:511];
  always @(posedge core_clk) begin
    instr <= mem[fetch_addr];
  end
endmodule // bid_prog_mem
`default_nettype wire

//--- sim/tb.sv
// Self-checking bench for the instruction decoder
`timescale 1ns/1ns
`default_nettype none
module tb;
  import bid_pkg::*;
  typedef struct {string nm; logic [15:0] v;} bid_exp_t;
  logic core_clk, rst_b, reg_wr, reg_rd, standby, rd_q, c, dc, z, sk;
  logic [11:0] instr;
  logic [8:0] fetch_addr;
  logic [7:0] port_pin_in, port_pin_out, port_pin_oe, a, b, r, v, k;
  logic [2:0] reg_addr, bb;
  logic [15:0] reg_wdata, reg_rdata;
  logic [4:0] t;
  logic [11:0] prog[$];
  bid_exp_t expq[$];
  int failures = 0;
  int checked = 0;
  logic [11:0] opc [7] = '{12'h1C0, 12'h080, 12'h140, 12'h100, 12'h180, 12'h340, 12'h300};
  logic [11:0] skc [4] = '{12'h2F0, 12'h3F0, 12'h610, 12'h710};

  bid_decoder DUT (.core_clk(core_clk), .rst_b(rst_b), .fetch_addr(fetch_addr),
    .instr(instr), .port_pin_in(port_pin_in), .port_pin_out(port_pin_out),
    .port_pin_oe(port_pin_oe), .standby(standby), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  bid_prog_mem MEM (.core_clk(core_clk), .fetch_addr(fetch_addr), .instr(instr));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge core_clk) begin : mon
    bid_exp_t e;
    rd_q <= reg_rd;
    if (rd_q === 1'b1) begin
      e = expq.pop_front();
      check(e.nm, reg_rdata, e.v);
    end
  end

  task automatic reg_op(input logic wr, input logic [2:0] ad, input logic [15:0] d);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= !wr;
    if (!wr) expq.push_back('{$sformatf("reg %0d", ad), d});
    @(posedge core_clk);
  endtask

  // Strobes drop only after the last transfer of a burst, never between two
  task automatic reg_idle();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask

  // Unused words branch to the halt address so a stray jump still ends
  task automatic load(input logic [8:0] h);
    rst_b <= 1'b0;
    repeat (20) @(posedge core_clk);
    for (int i = 0; i < 512; i++) MEM.mem[i] = {3'b101, h};
    foreach (prog[i]) MEM.mem[i] = prog[i];
  endtask

  task automatic go(input string nm, input logic [8:0] h, input logic [7:0] w,
                    input logic [15:0] st);
    int n;
    n = 0;
    rst_b <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (standby !== 1'b1 && fetch_addr !== h && n < 400);
    check("halt", 16'(n < 400), 16'h0001);
    reg_op(1'b0, BID_REG_ACC, {8'h00, w});
    reg_op(1'b0, BID_REG_STATUS, st);
    reg_idle();
    repeat (2) @(posedge core_clk);
    $display("test %s done", nm);
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    port_pin_in = 8'h00;
    a = 8'($urandom(10688));
    for (int j = 0; j < 2; j++) begin
      a = 8'($urandom);
      b = 8'($urandom);
      v = 8'($urandom);
      r = (a & b) | v;
      k = j ? r : 8'($urandom);
      prog = '{{4'hC, a}, {4'hE, b}, 12'h001, {4'hD, v}, 12'h00F, {4'hF, k}};
      load(9'h006);
      go("literal", 9'h006, r ^ k, {13'h0003, r == k, 2'b00});
    end
    for (int i = 0; i < 14; i++) begin
      a = 8'($urandom);
      b = 8'($urandom);
      case (i / 2)
        0: {c, r} = {1'b0, a} + {1'b0, b};
        1: {c, r} = {1'b1, a} - {1'b0, b};
        2: {c, r} = {1'b0, a & b};
        3: {c, r} = {1'b0, a | b};
        4: {c, r} = {1'b0, a ^ b};
        5: {c, r} = {a, 1'b0};
        default: {r, c} = {1'b0, a};
      endcase
      t = (i / 2 == 1) ? {1'b1, a[3:0]} - {1'b0, b[3:0]} : {1'b0, a[3:0]} + {1'b0, b[3:0]};
      dc = i < 4 && t[4];
      z = (i < 10 || i % 2 == 1) && r == 8'h00;
      prog = '{{4'hC, a}, 12'h030, {4'hC, b}, opc[i / 2] | 12'h010 | 12'(i % 2) << 5,
               (i % 2) ? 12'h210 : 12'h000};
      load(9'h005);
      go("byte_op", 9'h005, r, {13'h0003, z, dc, c});
    end
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'h01 : (i == 2) ? 8'hFF : 8'($urandom);
      bb = 3'($urandom);
      sk = i < 2 ? v == 8'h01 : i < 4 ? v == 8'hFF : v[bb] ^ (i < 6);
      prog = '{{4'hC, v}, 12'h030, skc[i / 2] | (i < 4 ? 12'h000 : 12'(bb) << 5),
               12'hC11, 12'h000};
      load(9'h005);
      go("skip", 9'h005, sk ? v : 8'h11, 16'h0018);
    end
    v = 8'($urandom);
    prog = '{12'h910, 12'h000};
    load(9'h002);
    MEM.mem[16] = {4'h8, v};
    go("return", 9'h002, v, 16'h0018);
    prog = '{12'hB00};
    load(9'h006);
    MEM.mem[256] = 12'hC05;
    MEM.mem[257] = 12'h022;
    MEM.mem[5] = 12'hC77;
    MEM.mem[261] = 12'hC99;
    go("pc_bit8", 9'h006, 8'h77, 16'h0018);
    v = 8'($urandom);
    if (v == 8'h3C) v = 8'hC3;
    port_pin_in <= v;
    prog = '{12'hCF0, 12'h006, 12'hC3C, 12'h005, 12'h026, 12'h226, 12'h206};
    load(9'h007);
    go("pins", 9'h007, v, {13'h0003, v == 8'h00, 2'b00});
    check("port_pin_oe", 16'(port_pin_oe), 16'h000F);
    check("port_pin_out", 16'(port_pin_out), 16'(v));
    // Timer write lands mid-way through the prescaler count; without the clear
    // the prescaler wraps before the read-back and the timer moves on by one
    prog = '{12'hC28, 12'h030, 12'h2F0, 12'hA02, 12'hC5A, 12'h021, 12'hC40, 12'h030,
             12'h2F0, 12'hA08, 12'h201};
    load(9'h00B);
    fork
      go("prescaler", 9'h00B, 8'h5A, 16'h0018);
      begin
        reg_op(1'b1, BID_REG_CTRL, 16'h0001);
        reg_idle();
      end
    join
    prog = '{12'hC42, 12'h003, 12'hC55, 12'h000};
    load(9'h1FF);
    go("standby", 9'h1FF, 8'h42, 16'h0030);
    check("standby", 16'(standby), 16'h0001);
    reg_op(1'b1, BID_REG_CTRL, 16'h0001);
    reg_op(1'b1, BID_REG_PC, 16'h0123);
    reg_op(1'b0, BID_REG_CTRL, 16'h0001);
    reg_op(1'b0, BID_REG_PC, 16'h0003);
    reg_op(1'b0, 3'h7, 16'h0000);
    reg_op(1'b0, BID_REG_OPTION, 16'h00FF);
    reg_idle();
    repeat (2) @(posedge core_clk);
    $display("test reg_port done");
    finish_test();
  end

  // About 30 programs, all but one under 80 cycles; 30000 cycles, over ten times that, is a hang
  initial begin
    repeat (30000) @(posedge core_clk);
    failures++;
    finish_test();
  end
endmodule // tb

bind bid_decoder bid_properties CHK (.core_clk(core_clk), .rst_b(rst_b),
  .fetch_addr(fetch_addr), .instr(instr), .port_pin_out(port_pin_out),
  .port_pin_oe(port_pin_oe), .standby(standby), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
`default_nettype wire
